// ===== logic/e1_host_ctrl.v
// Purpose: system-side controller driving the framer serial pins and host bus
// Assumes: one clock ref_clk, synchronous active-high reset
// Notes: tx_line_clock and rx_line_clock are made here by a divider
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "e1_host_defs.vh"
module e1_host_ctrl (
	input wire ref_clk,
	input wire reset,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr_stb,
	input wire rd_stb,
	output reg [7:0] rdata,
	output reg tx_line_clock,
	output reg rx_line_clock,
	output reg backplane_clock,
	output reg tx_serial_in,
	input wire tx_channel_clock,
	input wire rx_serial_out,
	input wire rx_channel_clock,
	input wire rx_boundary_sync_i,
	output reg rx_boundary_sync_o,
	output reg rx_boundary_sync_oe,
	output reg rx_line_positive,
	output reg rx_line_negative,
	input wire tx_line_positive,
	input wire tx_line_negative,
	input wire [7:0] muxed_host_bus_i,
	output reg [7:0] muxed_host_bus_o,
	output reg muxed_host_bus_oe,
	output reg bus_style_select,
	output reg chip_select_n,
	output reg address_strobe,
	output reg data_strobe,
	output reg rw_select,
	output reg busy
);
	localparam H_IDLE = 5'b00001;
	localparam H_ADDR = 5'b00010;
	localparam H_LATCH = 5'b00100;
	localparam H_DATA = 5'b01000;
	localparam H_END = 5'b10000;
	reg [7:0] ctrl_q;
	reg [7:0] cfg_q;
	reg [7:0] tx_byte_q;
	reg [7:0] rx_byte_q;
	reg [7:0] rx_slot_q;
	reg [7:0] haddr_q;
	reg [7:0] hdata_q;
	reg hwrite_q;
	reg [4:0] hstate_q;
	reg [3:0] hcnt_q;
	reg [7:0] div_q;
	reg [`BIT_W-1:0] tx_bit_q;
	reg [`SLOT_W-1:0] tx_slot_q;
	reg [7:0] tx_shift_q;
	reg tx_byte_taken_q;
	reg [`BIT_W-1:0] rx_bit_q;
	reg [`SLOT_W-1:0] rx_slot_cnt_q;
	reg [7:0] rx_shift_q;
	reg rx_frame_seen_q;
	reg rx_byte_new_q;
	reg chclk_seen_q;
	reg hcmd_go;
	reg [7:0] bus_meta_q;
	reg [7:0] bus_sync_q;
	wire tx_pos_lvl;
	wire tx_neg_lvl;
	wire tick_half;
	wire rx_lvl;
	wire rxs_lvl;
	wire rxs_rise;
	wire txc_rise;
	wire rxc_rise;
	wire nrz;

	assign nrz = ctrl_q[`CTRL_NRZ];
	assign tick_half = (div_q == `LINK_HALF_CYC - 8'd1);

	edge_sync u_rx_data (
		.ref_clk(ref_clk), .reset(reset), .async_in(rx_serial_out),
		.level(rx_lvl), .rise(), .fall());
	edge_sync u_rx_sync (
		.ref_clk(ref_clk), .reset(reset), .async_in(rx_boundary_sync_i),
		.level(rxs_lvl), .rise(rxs_rise), .fall());
	edge_sync u_tx_chclk (
		.ref_clk(ref_clk), .reset(reset), .async_in(tx_channel_clock),
		.level(), .rise(txc_rise), .fall());
	edge_sync u_rx_chclk (
		.ref_clk(ref_clk), .reset(reset), .async_in(rx_channel_clock),
		.level(), .rise(rxc_rise), .fall());
	edge_sync u_tx_pos (
		.ref_clk(ref_clk), .reset(reset), .async_in(tx_line_positive),
		.level(tx_pos_lvl), .rise(), .fall());
	edge_sync u_tx_neg (
		.ref_clk(ref_clk), .reset(reset), .async_in(tx_line_negative),
		.level(tx_neg_lvl), .rise(), .fall());

	always @(posedge ref_clk) begin
		if (reset) begin
			div_q <= 8'h00;
			tx_line_clock <= 1'b0;
			rx_line_clock <= 1'b0;
			backplane_clock <= 1'b0;
		end else begin
			div_q <= tick_half ? 8'h00 : div_q + 8'h01;
			if (tick_half) begin
				tx_line_clock <= ~tx_line_clock;
				rx_line_clock <= ~rx_line_clock;
				backplane_clock <= ctrl_q[`CTRL_BACKPLANE_CLOCK_EN] & ~backplane_clock;
			end
		end
	end

	// transmit side: change data on rising link clock
	always @(posedge ref_clk) begin
		if (reset) begin
			tx_bit_q <= {`BIT_W{1'b0}};
			tx_slot_q <= {`SLOT_W{1'b0}};
			tx_shift_q <= 8'h00;
			tx_serial_in <= 1'b0;
			tx_byte_taken_q <= 1'b0;
		end else begin
			if (wr_stb && addr == `REG_TX_BYTE)
				tx_byte_taken_q <= 1'b0;
			if (tick_half && !tx_line_clock && ctrl_q[`CTRL_TX_EN]) begin
				// stable before the falling sample edge
				if (tx_bit_q == {`BIT_W{1'b0}}) begin
					tx_serial_in <= tx_byte_q[7];
					tx_shift_q <= {tx_byte_q[6:0], 1'b0};
					tx_byte_taken_q <= 1'b1;
				end else begin
					tx_serial_in <= tx_shift_q[7];
					tx_shift_q <= {tx_shift_q[6:0], 1'b0};
				end
				tx_bit_q <= tx_bit_q + 3'd1;
				// slot 31 wraps to slot 0
				if (tx_bit_q == `LAST_BIT)
					tx_slot_q <= (tx_slot_q == `LAST_SLOT) ? 5'd0 : tx_slot_q + 5'd1;
			end
			// realign bit count on LSB marker
			if (txc_rise)
				tx_bit_q <= {`BIT_W{1'b0}};
		end
	end

	// receive line drive and serial capture
	always @(posedge ref_clk) begin
		if (reset) begin
			rx_line_positive <= 1'b0;
			rx_line_negative <= 1'b0;
			rx_bit_q <= {`BIT_W{1'b0}};
			rx_slot_cnt_q <= {`SLOT_W{1'b0}};
			rx_shift_q <= 8'h00;
			rx_byte_q <= 8'h00;
			rx_slot_q <= 8'h00;
			rx_frame_seen_q <= 1'b0;
			rx_byte_new_q <= 1'b0;
			chclk_seen_q <= 1'b0;
		end else begin
			// change before the falling sample edge
			if (tick_half && !rx_line_clock) begin
				rx_line_positive <= tx_pos_lvl;
				rx_line_negative <= nrz ? tx_pos_lvl : tx_neg_lvl;
			end
			if (rd_stb && addr == `REG_RX_BYTE)
				rx_byte_new_q <= 1'b0;
			if (rxc_rise)
				chclk_seen_q <= 1'b1;
			// sample mid-bit on the falling edge
			if (tick_half && rx_line_clock && ctrl_q[`CTRL_RX_EN]) begin
				rx_shift_q <= {rx_shift_q[6:0], rx_lvl};
				rx_bit_q <= rx_bit_q + 3'd1;
				if (rx_bit_q == `LAST_BIT) begin
					rx_byte_q <= {rx_shift_q[6:0], rx_lvl};
					rx_slot_q <= {3'b000, rx_slot_cnt_q} + 8'd1;
					rx_byte_new_q <= 1'b1;
					rx_slot_cnt_q <= rx_slot_cnt_q + 5'd1;
				end
			end
			if (rxs_rise && !rx_boundary_sync_oe) begin
				rx_bit_q <= {`BIT_W{1'b0}};
				rx_slot_cnt_q <= {`SLOT_W{1'b0}};
				rx_frame_seen_q <= 1'b1;
			end
		end
	end

	// drive frame pulse when CTRL_SYNC_DRIVE makes pin an output
	always @(posedge ref_clk) begin
		if (reset) begin
			rx_boundary_sync_o <= 1'b0;
			rx_boundary_sync_oe <= 1'b0;
		end else begin
			rx_boundary_sync_oe <= ctrl_q[`CTRL_SYNC_DRIVE];
			if (tick_half && !rx_line_clock)
				rx_boundary_sync_o <= ctrl_q[`CTRL_SYNC_DRIVE] &&
					rx_slot_cnt_q == 5'd0 && rx_bit_q == 3'd0;
		end
	end

	// software register port
	always @(posedge ref_clk) begin
		if (reset) begin
			ctrl_q <= `CTRL_RESET;
			cfg_q <= `CFG_RESET;
			tx_byte_q <= 8'h00;
			haddr_q <= 8'h00;
			hdata_q <= 8'h00;
			hwrite_q <= 1'b0;
			rdata <= 8'h00;
			bus_meta_q <= 8'h00;
			bus_sync_q <= 8'h00;
		end else begin
			bus_meta_q <= muxed_host_bus_i;
			bus_sync_q <= bus_meta_q;
			if (wr_stb) begin
				case (addr)
				`REG_CTRL: ctrl_q <= wdata;
				`REG_CFG: cfg_q <= wdata;
				`REG_TX_BYTE: tx_byte_q <= wdata;
				`REG_HADDR: haddr_q <= wdata;
				`REG_HDATA: hdata_q <= wdata;
				`REG_HCMD: if (hstate_q == H_IDLE) hwrite_q <= wdata[0];
				default: ;
				endcase
			end
			if (hstate_q == H_DATA && hcnt_q == `HOST_PHASE_CYC - 4'd1 && !hwrite_q)
				hdata_q <= bus_sync_q;
			if (rd_stb) begin
				case (addr)
				`REG_CTRL: rdata <= ctrl_q;
				`REG_STATUS: rdata <= {2'b00, chclk_seen_q, rx_frame_seen_q, rxs_lvl,
					rx_byte_new_q, tx_byte_taken_q, busy};
				`REG_TX_BYTE: rdata <= tx_byte_q;
				`REG_RX_BYTE: rdata <= rx_byte_q;
				`REG_RX_SLOT: rdata <= rx_slot_q;
				`REG_CFG: rdata <= cfg_q;
				`REG_HADDR: rdata <= haddr_q;
				`REG_HDATA: rdata <= hdata_q;
				default: rdata <= 8'h00;
				endcase
			end else
				rdata <= 8'h00;
		end
	end

	always @* begin
		hcmd_go = wr_stb && addr == `REG_HCMD && hstate_q == H_IDLE;
	end

	always @(posedge ref_clk) begin
		if (reset) begin
			hstate_q <= H_IDLE;
			hcnt_q <= 4'h0;
			busy <= 1'b0;
			bus_style_select <= 1'b0;
			chip_select_n <= 1'b1;
			address_strobe <= 1'b0;
			data_strobe <= 1'b0;
			rw_select <= 1'b0;
			muxed_host_bus_o <= 8'h00;
			muxed_host_bus_oe <= 1'b0;
		end else begin
			// strap: 1 strobe style, 0 read/write style
			bus_style_select <= cfg_q[0];
			hcnt_q <= (hcnt_q == `HOST_PHASE_CYC - 4'd1) ? 4'h0 : hcnt_q + 4'h1;
			case (hstate_q)
			H_IDLE: begin
				hcnt_q <= 4'h0;
				if (hcmd_go) begin
					busy <= 1'b1;
					chip_select_n <= 1'b0;
					muxed_host_bus_o <= haddr_q;
					muxed_host_bus_oe <= 1'b1;
					address_strobe <= 1'b1;
					rw_select <= ~wdata[0];
					hstate_q <= H_ADDR;
				end
			end
			H_ADDR: if (hcnt_q == `HOST_PHASE_CYC - 4'd1) begin
				address_strobe <= 1'b0;
				hstate_q <= H_LATCH;
			end
			H_LATCH: if (hcnt_q == `HOST_PHASE_CYC - 4'd1) begin
				muxed_host_bus_o <= hdata_q;
				muxed_host_bus_oe <= hwrite_q;
				// strobe: driven high-active in both styles, whatever bus_style_select is
				data_strobe <= 1'b1;
				hstate_q <= H_DATA;
			end
			H_DATA: if (hcnt_q == `HOST_PHASE_CYC - 4'd1) begin
				data_strobe <= 1'b0;
				hstate_q <= H_END;
			end
			H_END: if (hcnt_q == `HOST_PHASE_CYC - 4'd1) begin
				muxed_host_bus_oe <= 1'b0;
				chip_select_n <= 1'b1;
				busy <= 1'b0;
				hstate_q <= H_IDLE;
			end
			default: hstate_q <= H_IDLE;
			endcase
		end
	end
endmodule // e1_host_ctrl

// ===== common/e1_host_defs.vh
// Purpose: constants for the serial-side controller that drives the framer
// Assumes: ref_clk 250 MHz, link clocks 2.048 MHz
// Notes: command register offsets are local to this controller
`ifndef E1_HOST_DEFS_VH
`define E1_HOST_DEFS_VH
`define SLOTS_PER_FRAME 6'd32
`define BITS_PER_SLOT 4'd8
`define SLOT_W 5
`define BIT_W 3
`define LAST_BIT 3'd7
`define LAST_SLOT 5'd31
`define REG_CTRL 8'h00
`define REG_STATUS 8'h01
`define REG_TX_BYTE 8'h02
`define REG_RX_BYTE 8'h03
`define REG_RX_SLOT 8'h04
`define REG_CFG 8'h05
`define REG_HADDR 8'h06
`define REG_HDATA 8'h07
`define REG_HCMD 8'h08
`define CTRL_TX_EN 0
`define CTRL_RX_EN 1
`define CTRL_NRZ 2
`define CTRL_SYNC_DRIVE 3
`define CTRL_BACKPLANE_CLOCK_EN 4
`define CTRL_RESET 8'h00
`define CFG_RESET 8'h00
`define REF_CLK_MHZ 250
`define LINK_HALF_NS 244
// divider for 2.048 MHz: 250e6/2.048e6 = 122.07, half period 61 cycles
`define LINK_HALF_CYC 8'd61
`define HOST_PHASE_CYC 4'd8
`endif

// ===== logic/edge_sync.v
// Purpose: two-flop synchroniser with rise and fall detect
// Assumes: input from outside the ref_clk domain
// Notes: first flop is read only by the second
`timescale 1ns/10ps
module edge_sync (
	input wire ref_clk,
	input wire reset,
	input wire async_in,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta_q;
	reg sync_q;
	reg prev_q;
	always @(posedge ref_clk) begin
		if (reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule // edge_sync

// ===== tb/e1_host_monitor.sv
// Purpose: pin checker for e1_host_ctrl
// Assumes: one clock, sync reset
// Notes: bound below
`timescale 1ns/10ps
module e1_host_monitor (
	input wire ref_clk,
	input wire reset,
	input wire tx_line_clock,
	input wire rx_line_clock,
	input wire tx_serial_in,
	input wire chip_select_n,
	input wire address_strobe,
	input wire data_strobe,
	input wire muxed_host_bus_oe,
	input wire busy
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (reset);
property p_cs_held; data_strobe |-> !chip_select_n; endproperty
a_cs_held: assert property (p_cs_held) else $error("strobe w/o select");
property p_addr_first; $fell(chip_select_n) |-> address_strobe && muxed_host_bus_oe; endproperty
a_addr_first: assert property (p_addr_first) else $error("no address phase");
property p_apart; address_strobe |-> !data_strobe; endproperty
a_apart: assert property (p_apart) else $error("strobes overlap");
property p_ds_len; $rose(data_strobe) |-> data_strobe [*8] ##1 !data_strobe; endproperty
a_ds_len: assert property (p_ds_len) else $error("data phase length");
property p_tx_clk; $rose(tx_line_clock) |-> ##60 tx_line_clock ##[1:2] !tx_line_clock; endproperty
a_tx_clk: assert property (p_tx_clk) else $error("tx clock period");
property p_rx_clk; $fell(rx_line_clock) |-> ##60 !rx_line_clock ##[1:2] rx_line_clock; endproperty
a_rx_clk: assert property (p_rx_clk) else $error("rx clock period");
property p_tx_data; $changed(tx_serial_in) |-> tx_line_clock; endproperty
a_tx_data: assert property (p_tx_data) else $error("data moved near fall");
property p_busy; $rose(busy) |-> ##[30:36] !busy; endproperty
a_busy: assert property (p_busy) else $error("access too long");
endmodule // e1_host_monitor
bind e1_host_ctrl e1_host_monitor mon_u (.ref_clk(ref_clk), .reset(reset),
	.tx_line_clock(tx_line_clock), .rx_line_clock(rx_line_clock), .tx_serial_in(tx_serial_in),
	.chip_select_n(chip_select_n), .address_strobe(address_strobe), .data_strobe(data_strobe),
	.muxed_host_bus_oe(muxed_host_bus_oe), .busy(busy));

// ===== tb/e1_framer_model.sv
// Purpose: behavioural framer pins
// Assumes: link clocks from controller
// Notes: released bus shows inverted data
`timescale 1ns/10ps
module e1_framer_model (
	input wire tx_line_clock,
	input wire rx_line_clock,
	input wire tx_serial_in,
	input wire rx_line_positive,
	input wire rx_line_negative,
	input wire [7:0] muxed_host_bus_o,
	input wire muxed_host_bus_oe,
	input wire chip_select_n,
	input wire address_strobe,
	input wire data_strobe,
	input wire rw_select,
	output wire tx_channel_clock,
	output reg tx_line_positive = 1'b0,
	output wire tx_line_negative,
	output wire rx_serial_out,
	output wire rx_channel_clock,
	output wire rx_sync,
	output wire [7:0] muxed_host_bus_i
);
reg [2:0] tb_q = 3'h0;
reg [2:0] rb_q = 3'h0;
reg [4:0] rs_q = 5'h00;
reg [7:0] sh_q = 8'h00;
reg [7:0] txb_q = 8'h00;
reg [7:0] adr_q = 8'h00;
reg [1:0] rl_q = 2'h0;
reg [7:0] mem [0:255];
wire [7:0] rbyte = {3'h2, rs_q};
wire drv = !chip_select_n && data_strobe && rw_select;
// bit count, line update on rise
always @(posedge tx_line_clock) begin
	tb_q <= tb_q + 3'h1;
	tx_line_positive <= sh_q[0];
end
assign tx_channel_clock = (tb_q == 3'h7);
assign tx_line_negative = 1'b0;
always @(negedge tx_line_clock) begin
	sh_q <= {sh_q[6:0], tx_serial_in};
	if (tb_q == 3'h7) txb_q <= {sh_q[6:0], tx_serial_in};
end
// slot pattern, msb first, store bypassed
always @(posedge rx_line_clock) begin
	rb_q <= rb_q + 3'h1;
	if (rb_q == 3'h7) rs_q <= rs_q + 5'h01;
end
assign rx_serial_out = rbyte[3'h7 - rb_q];
assign rx_channel_clock = (rb_q == 3'h7);
assign rx_sync = (rb_q == 3'h0) && (rs_q == 5'h00);
always @(negedge rx_line_clock) rl_q <= {rx_line_positive, rx_line_negative};
always @(negedge address_strobe) if (!chip_select_n) adr_q <= muxed_host_bus_i;
always @(negedge data_strobe) if (!chip_select_n && !rw_select) mem[adr_q] <= muxed_host_bus_i;
assign muxed_host_bus_i = muxed_host_bus_oe ? muxed_host_bus_o : (drv ? mem[adr_q] : ~mem[adr_q]);
endmodule // e1_framer_model

// ===== tb/testbench.sv
// Purpose: self-checking bench for e1_host_ctrl
// Assumes: framer model on far side
// Notes: link clocks come from the controller
`timescale 1ns/10ps
`include "e1_host_defs.vh"
module testbench;
reg ref_clk = 1'b0;
reg reset = 1'b1;
reg wr_stb = 1'b0;
reg rd_stb = 1'b0;
reg [7:0] addr = 8'h00;
reg [7:0] wdata = 8'h00;
reg [7:0] v;
reg [7:0] c;
wire [7:0] rdata, muxed_host_bus_i, muxed_host_bus_o;
wire tx_line_clock, rx_line_clock, backplane_clock, tx_serial_in, tx_channel_clock;
wire rx_serial_out, rx_channel_clock, rx_sync, rx_boundary_sync_o, rx_boundary_sync_oe;
wire rx_line_positive, rx_line_negative, tx_line_positive, tx_line_negative;
wire muxed_host_bus_oe, bus_style_select, chip_select_n, address_strobe, data_strobe;
wire rw_select, busy;
wire rx_boundary_sync_i = rx_boundary_sync_oe ? rx_boundary_sync_o : rx_sync;
integer error_cnt = 0;
integer num_checks = 0;
integer n;
integer bp_n = 0;
always #2 ref_clk = ~ref_clk;
always @(posedge backplane_clock) bp_n = bp_n + 1;
e1_host_ctrl dut_u (.*);
e1_framer_model frm_u (.*);
task wr(input [7:0] a, input [7:0] d);
	begin
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
		@(posedge ref_clk);
	end
endtask
task rd(input [7:0] a, output [7:0] d);
	begin
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		@(posedge ref_clk);
		d = rdata;
	end
endtask
task chk(input [7:0] g, input [7:0] e);
	begin
		num_checks = num_checks + 1;
		if (g !== e) begin
			error_cnt = error_cnt + 1;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	end
endtask
task conclude;
	begin
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
endtask
initial begin
	repeat (20) @(posedge ref_clk);
	reset <= 1'b0;
	@(posedge ref_clk);
	chk({7'h00, chip_select_n}, 8'h01);
	wr(8'h20, 8'h5a);
	rd(8'h20, v);
	chk(v, 8'h00);
	for (n = 0; n < 2; n = n + 1) begin
		wr(`REG_CFG, n[7:0]);
		wr(`REG_HADDR, 8'h35 + n[7:0]);
		wr(`REG_HDATA, 8'ha5 ^ n[7:0]);
		wr(`REG_HCMD, 8'h01);
		wr(`REG_HCMD, 8'h00);
		repeat (40) @(posedge ref_clk);
		chk({7'h00, bus_style_select}, n[7:0]);
		chk(frm_u.mem[8'h35 + n[7:0]], 8'ha5 ^ n[7:0]);
		wr(`REG_HDATA, 8'h00);
		wr(`REG_HCMD, 8'h00);
		repeat (40) @(posedge ref_clk);
		rd(`REG_HDATA, v);
		chk(v, 8'ha5 ^ n[7:0]);
	end
	$display("done: host bus");
	wr(`REG_CTRL, 8'h03);
	wr(`REG_TX_BYTE, 8'hb4);
	for (n = 0; n < 20 && frm_u.txb_q !== 8'hb4; n = n + 1) @(posedge tx_channel_clock);
	@(posedge ref_clk);
	chk(frm_u.txb_q, 8'hb4);
	$display("done: transmit");
	repeat (31300) @(posedge ref_clk);
	rd(`REG_STATUS, v);
	chk(v & 8'h30, 8'h30);
	$display("done: frame");
	v = 8'h00;
	for (n = 0; n < 1500 && v[2] !== 1'b1; n = n + 1) rd(`REG_STATUS, v);
	rd(`REG_RX_BYTE, v);
	rd(`REG_RX_SLOT, c);
	chk(v, 8'h3f + c);
	$display("done: receive");
	chk(bp_n[7:0], 8'h00);
	wr(`REG_CTRL, 8'h1b);
	repeat (600) @(posedge ref_clk);
	chk({7'h00, rx_boundary_sync_oe}, 8'h01);
	chk({7'h00, bp_n > 2}, 8'h01);
	$display("done: pins");
	conclude;
end
initial begin
	repeat (60000) @(posedge ref_clk);
	error_cnt = error_cnt + 1;
	conclude;
end
endmodule // testbench
